// *** verilog/mnd_core.sv ***
`timescale 1ns/1ns
`include "mnd_consts.svh"
// Notes on behaviour
// [RULE1] Copy opcode 001000, bit 7 destination, 7-bit address.
// [RULE2] Destination 0 writes work, 1 writes file.
// [RULE3] Copy updates zero flag for either destination.
// [RULE4] Store work into file, flags unchanged.
// [RULE5] Literal load into work, bits 9:8 ignored.
// [RULE6] Source fills literal don't-care bits with zeros.
// [RULE7] No-operation changes nothing, only advances counter.
module mnd_core
   import mnd_pkg::*;
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // Instruction in.
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   // File register read port, combinational.
   output logic [6:0] o_file_addr,
   input wire logic [7:0] i_file_rdata,
   // File register write strobe.
   output logic o_file_we,
   output logic [6:0] o_file_waddr,
   output logic [7:0] o_file_wdata,
   // Working register, zero flag, counter advance.
   output logic [7:0] o_work,
   output logic o_zero,
   output logic o_pc_inc,
   output logic o_illegal
);
   mnd_op_t op;
   logic [7:0] work;
   logic zero;
   logic go_copy, go_store, go_lit, go_nop;
   logic next_file_we;

   mnd_decode u_dec (
      .i_instr(i_instr),
      .o_op(op)
   );

   assign go_copy = i_instr_valid && op == MND_OP_COPY;
   assign go_store = i_instr_valid && op == MND_OP_STORE;
   assign go_lit = i_instr_valid && op == MND_OP_LIT;
   assign go_nop = i_instr_valid && op == MND_OP_NOP;
   // One write strobe serves both sources, since the two classes never coincide.
   assign next_file_we = go_store || (go_copy && i_instr[`MND_DEST_BIT]); // [RULE2]

   // The read address is taken straight from the word so the operand arrives this cycle.
   assign o_file_addr = i_instr[`MND_ADDR_MSB:`MND_ADDR_LSB]; // [RULE1]
   assign o_work = work;
   assign o_zero = zero;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         work <= `MND_W_RESET;
      end else if (go_copy && !i_instr[`MND_DEST_BIT]) begin
         work <= i_file_rdata; // [RULE2]
      end else if (go_lit) begin
         work <= i_instr[`MND_LIT_VAL_MSB:`MND_LIT_VAL_LSB]; // [RULE5]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         zero <= `MND_Z_RESET;
      end else if (go_copy) begin
         zero <= (i_file_rdata == 8'h00); // [RULE3]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_file_we <= 1'b0;
      end else begin
         o_file_we <= next_file_we; // [RULE2]
      end
   end

   // Address and data load only with a write, so the write bus stays quiet otherwise.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_file_waddr <= 7'h00;
      end else if (next_file_we) begin
         o_file_waddr <= i_instr[`MND_ADDR_MSB:`MND_ADDR_LSB]; // [RULE4]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_file_wdata <= 8'h00;
      end else if (next_file_we) begin
         o_file_wdata <= go_store ? work : i_file_rdata; // [RULE4]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pc_inc <= 1'b0;
      end else begin
         o_pc_inc <= go_copy || go_store || go_lit || go_nop; // [RULE7]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_illegal <= 1'b0;
      end else begin
         o_illegal <= i_instr_valid && op == MND_OP_ILLEGAL;
      end
   end

   // Assertions.
   copy_to_work_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE2]
      go_copy && !i_instr[7] |=> work == $past(i_file_rdata) && !o_file_we)
      else $error("copy to work failed");

   copy_to_file_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE2]
      go_copy && i_instr[7] |=> o_file_we && o_file_wdata == $past(i_file_rdata)
      && o_file_waddr == $past(i_instr[6:0]) && work == $past(work))
      else $error("copy to file failed");

   copy_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE3]
      go_copy |=> zero == ($past(i_file_rdata) == 8'h00))
      else $error("zero flag wrong");

   store_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE4]
      go_store |=> o_file_we && o_file_wdata == $past(work) && $stable(zero))
      else $error("store failed");

   literal_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE5]
      go_lit |=> work == $past(i_instr[7:0]) && $stable(zero) && !o_file_we)
      else $error("literal load failed");

   copy_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE1]
      i_instr_valid && i_instr[13:8] == 6'h08 |=> o_pc_inc && !o_illegal)
      else $error("copy not single cycle");

   nop_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE7]
      go_nop |=> o_pc_inc && !o_file_we && $stable(work) && $stable(zero))
      else $error("nop changed state");

   idle_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE7]
      !i_instr_valid |=> !o_file_we && !o_pc_inc && $stable(work))
      else $error("idle changed state");

   store_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE4]
      go_store
      |=> o_file_waddr == $past(i_instr[6:0]) && $stable(work))
      else $error("store address wrong");

   store_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE4]
      i_instr_valid && i_instr[13:7] == 7'h01
      |=> o_pc_inc && o_file_we && !o_illegal)
      else $error("store not single cycle");

   literal_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE5]
      i_instr_valid && i_instr[13:10] == 4'hc
      |=> o_pc_inc && !o_illegal && o_work == $past(i_instr[7:0]))
      else $error("literal not single cycle");

   nop_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE7]
      i_instr_valid && (i_instr & 14'h3f9f) == 14'h0000
      |=> o_pc_inc && !o_illegal && !o_file_we)
      else $error("no-operation not decoded");

   work_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE2]
      !$stable(work)
      |-> $past(go_lit || (go_copy && !i_instr[7])))
      else $error("work changed without cause");

   zero_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE3]
      !$stable(zero)
      |-> $past(go_copy))
      else $error("zero flag changed without copy");

   write_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE2]
      o_file_we
      |-> $past(go_store || (go_copy && i_instr[7])))
      else $error("write without cause");

   refused_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_instr_valid && op == MND_OP_ILLEGAL
      |=> o_illegal && !o_pc_inc && !o_file_we && $stable(work) && $stable(zero))
      else $error("refused word changed state");

   idle_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE7]
      !i_instr_valid
      |=> $stable(zero) && !o_illegal)
      else $error("idle changed flags");

   store_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE4]
      go_store
      |=> o_pc_inc && !o_illegal && o_file_wdata == $past(o_work))
      else $error("store pulse wrong");

   copy_file_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE3]
      go_copy && i_instr[7] && i_file_rdata == 8'h00
      |=> o_zero && o_file_we)
      else $error("file copy of zero missed flag");

   advance_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE7]
      o_pc_inc
      |-> $past(i_instr_valid) && !o_illegal)
      else $error("advance without instruction");

   refusal_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_illegal
      |-> $past(i_instr_valid) && !o_file_we)
      else $error("refusal without instruction");

   // Cover points.
   copy_cov_c: cover property (@(posedge i_sys_clk) go_copy && i_instr[7]);
   illegal_cov_c: cover property (@(posedge i_sys_clk) i_instr_valid && op == MND_OP_ILLEGAL);
   store_cov_c: cover property (@(posedge i_sys_clk) go_store);
   lit_cov_c: cover property (@(posedge i_sys_clk) go_lit ##1 go_copy);
   nop_cov_c: cover property (@(posedge i_sys_clk) go_nop);
endmodule

// *** shared/mnd_consts.svh ***
`ifndef MND_CONSTS_SVH
`define MND_CONSTS_SVH
`define MND_COPY_OP 6'h08
`define MND_COPY_MSB 13
`define MND_COPY_LSB 8
`define MND_STORE_OP 7'h01
`define MND_STORE_MSB 13
`define MND_STORE_LSB 7
`define MND_LIT_OP 4'hc
`define MND_LIT_MSB 13
`define MND_LIT_LSB 10
`define MND_DEST_BIT 7
`define MND_ADDR_MSB 6
`define MND_ADDR_LSB 0
`define MND_LIT_VAL_MSB 7
`define MND_LIT_VAL_LSB 0
`define MND_NOP_MASK 14'h3f9f
`define MND_NOP_VAL 14'h0000
`define MND_W_RESET 8'h00
`define MND_Z_RESET 1'h0
`endif

// *** shared/mnd_pkg.sv ***
package mnd_pkg;
   typedef enum logic [2:0] {
      MND_OP_ILLEGAL = 3'h0,
      MND_OP_COPY = 3'h1,
      MND_OP_STORE = 3'h3,
      MND_OP_LIT = 3'h2,
      MND_OP_NOP = 3'h6
   } mnd_op_t;
endpackage

// *** verilog/mnd_decode.sv ***
`timescale 1ns/1ns
`include "mnd_consts.svh"
module mnd_decode
   import mnd_pkg::*;
(
   // Instruction word.
   input wire logic [13:0] i_instr,
   // Decoded class.
   output mnd_op_t o_op
);
   always_comb begin
      if (i_instr[`MND_COPY_MSB:`MND_COPY_LSB] == `MND_COPY_OP) begin
         o_op = MND_OP_COPY; // [RULE1]
      end else if (i_instr[`MND_STORE_MSB:`MND_STORE_LSB] == `MND_STORE_OP) begin
         o_op = MND_OP_STORE; // [RULE4]
      end else if (i_instr[`MND_LIT_MSB:`MND_LIT_LSB] == `MND_LIT_OP) begin
         o_op = MND_OP_LIT; // [RULE5]
      end else if ((i_instr & `MND_NOP_MASK) == `MND_NOP_VAL) begin
         o_op = MND_OP_NOP; // [RULE7]
      end else begin
         o_op = MND_OP_ILLEGAL;
      end
   end
endmodule

// *** sim/mnd_prog_mem.sv ***
`timescale 1ns/1ns
module mnd_prog_mem (
   // Instruction fields.
   input wire logic [2:0] i_kind,
   input wire logic [6:0] i_addr,
   input wire logic i_dest,
   input wire logic [7:0] i_lit,
   input wire logic [1:0] i_pad,
   // Assembled word.
   output logic [13:0] o_word
);
   always_comb begin
      case (i_kind)
         3'h0: o_word = {6'h08, i_dest, i_addr};
         3'h1: o_word = {7'h01, i_addr};
         3'h2: o_word = {4'hc, 2'h0, i_lit};
         3'h3: o_word = {7'h00, i_pad, 5'h00};
         default: o_word = 14'h3fff;
      endcase
   end
endmodule

// *** sim/mnd_core_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module mnd_core_tb_top;
   import mnd_pkg::*;
   logic i_sys_clk = 0, i_resetn = 0, i_instr_valid = 0, dest = 0, zero = 0;
   logic o_file_we, o_zero, o_pc_inc, o_illegal;
   logic [2:0] kind = 0;
   logic [1:0] pad = 0;
   logic [6:0] addr = 0, o_file_addr, o_file_waddr;
   logic [7:0] lit = 0, rdata = 0, w = 0, o_file_wdata, o_work;
   logic [13:0] word;
   logic [26:0] nt, got;
   logic [26:0] notes[$];
   int err_count = 0, total_checks = 0;
   mnd_prog_mem i_mem (.i_kind(kind), .i_addr(addr), .i_dest(dest), .i_lit(lit),
      .i_pad(pad), .o_word(word));
   mnd_core i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid),
      .i_instr(word), .o_file_addr(o_file_addr), .i_file_rdata(rdata), .o_file_we(o_file_we),
      .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata), .o_work(o_work),
      .o_zero(o_zero), .o_pc_inc(o_pc_inc), .o_illegal(o_illegal));
   initial forever #25 i_sys_clk = ~i_sys_clk;
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Write address and data only mean something while the strobe is high.
   always @(posedge i_sys_clk) begin
      #1;
      if (o_pc_inc === 1'b1 || o_illegal === 1'b1) begin
         // An empty queue yields a note that no legal answer can match.
         nt = notes.size() ? notes.pop_front() : 27'h7ffffff;
         got = {o_illegal, o_pc_inc, o_file_we,
            o_file_we ? {o_file_waddr, o_file_wdata} : 15'h0, o_work, o_zero};
         `CHK(got, nt)
      end
   end
   initial begin
      void'($urandom(72604));
      // The second pass starts with a reset in mid-run, so the model returns to reset values.
      for (int pass = 0; pass < 2; pass++) begin
         @(negedge i_sys_clk) i_resetn = 0;
         w = 8'h00;
         zero = 1'b0;
         repeat (4) @(posedge i_sys_clk);
         #1;
         `CHK({o_work, o_zero, o_file_we, o_pc_inc, o_illegal}, 12'h000)
         @(negedge i_sys_clk) i_resetn = 1;
         for (int n = 0; n < 400; n++) begin
            @(negedge i_sys_clk);
            kind = (n < 5) ? n[2:0] : 3'($urandom_range(4));
            addr = 7'($urandom);
            dest = 1'($urandom);
            pad = 2'($urandom);
            lit = (n % 8 == 0) ? 8'h00 : 8'($urandom);
            rdata = (n % 3 == 0) ? 8'h00 : 8'($urandom);
            i_instr_valid = (n % 7 != 6);
            if (i_instr_valid) begin
               case (kind)
                  3'h0: begin
                     zero = (rdata == 8'h00);
                     if (!dest) w = rdata;
                     nt = {2'b01, dest, dest ? {addr, rdata} : 15'h0, w, zero};
                  end
                  3'h1: nt = {3'b011, addr, w, w, zero};
                  3'h2: begin
                     w = lit;
                     nt = {3'b010, 15'h0, w, zero};
                  end
                  3'h3: nt = {3'b010, 15'h0, w, zero};
                  default: nt = {3'b100, 15'h0, w, zero};
               endcase
               notes.push_back(nt);
            end
            #1;
            if (kind < 3'h2) `CHK(o_file_addr, addr)
         end
         @(negedge i_sys_clk) i_instr_valid = 0;
         repeat (3) @(posedge i_sys_clk);
         `CHK(notes.size(), 0)
      end
      give_verdict;
   end
endmodule
